// file: core/global_clock_reset_interrupt_ctrl.sv
// Global clock, reset and interrupt resources of a T1/E1 transceiver.
// Assumes an APB master on core_clk; events arrive as core_clk pulses.
//
// Notes on behaviour
// R1: Master clock at base rate or up to 8x.
// R2: Backplane rate 2.048, 4.096, 8.192 or 16.384 MHz.
// R3: Clock control sets reference pin direction and T1 or E1 output.
// R4: Reference: prescaled master, reference pin or recovered clock.
// R5: Master or recovered reference lets the pin drive 2.048/1.544 MHz.
// R6: As bus master, drive 8 kHz frame sync with the backplane clock.
// R7: Hardware reset resets framers, line interface and testers.
// R8: Host rewrites all registers, reserved ones to zero, after reset.
// R9: Power-down bits float transmit pins and stop the receiver.
// R10: Enable clear floats transmit outputs; interface stays powered.
// R11: Global framer and LIU reset bit 0 reset those blocks.
// R12: Mode register bit 1 resets its framer.
// R13: HDLC control bits 6 and 5 reset receive and transmit HDLC.
// R14: Elastic bit 2 and bit-code bit 7 reset those blocks.
// R15: Code definition writes restart integration.
// R16: Host waits 300 ns after clock control write with 1.544 MHz master.
// R17: Host follows reset, identify, clocks, zero, framer, LIU, done order.
// R18: Global registers sit at indices F0 to FF.
// R19: Global info names the block; lower levels name the source.
// R20: Info bits are live; clear once no unmasked latched bit remains.
// R21: Latched bits clear on a written 1 only.
// R22: Mask keeps a bit off info and pin, but latched bit still sets.
// R23: Open-drain pin pulled low while any unmasked condition is active.
// R24: Pin asserts with any global info bit, releases in the same cycle.
`timescale 1ns/100ps

module global_clock_reset_interrupt_ctrl
    import global_ctrl_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A, // Arbitrary value
    parameter int EVT_W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [global_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [global_ctrl_pkg::APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [global_ctrl_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EVT_W-1:0] tx_events,
    input wire logic [EVT_W-1:0] rx_events_a,
    input wire logic [EVT_W-1:0] rx_events_b,
    input wire logic [EVT_W-1:0] liu_events,
    input wire logic [EVT_W-1:0] tester_events,
    output logic irq_n_o,
    output logic irq_n_oe,
    input wire logic master_clk_t1_rate,
    input wire logic master_clk_e1_rate,
    input wire logic rx_recovered_clk,
    input wire logic ref_clk_pin_i,
    output logic ref_clk_pin_o,
    output logic ref_clk_pin_oe,
    output logic bp_ref_clk,
    output logic [1:0] bp_rate_sel,
    output logic [2:0] mclk_prescale,
    output logic mclk_base_t1,
    output logic tx_frame_sync_pin_o,
    output logic tx_frame_sync_pin_oe,
    output logic rx_framer_rst,
    output logic tx_framer_rst,
    output logic tester_rst,
    output logic liu_rst,
    output logic rx_hdlc_rst,
    output logic tx_hdlc_rst,
    output logic rx_elastic_rst,
    output logic tx_elastic_rst,
    output logic rx_bitcode_rst,
    output logic code_integ_restart,
    output logic rx_framer_enable,
    output logic tx_framer_enable,
    output logic tx_power_down,
    output logic rx_power_down,
    output logic tx_line_oe
);
    import global_ctrl_pkg::*;

    if (EVT_W < 1 || EVT_W > REG_W) begin : g_bad_evt_w
        $error("EVT_W must be 1 to 8");
    end

    logic [IDX_W-1:0] idx;
    logic wr_access;
    logic [REG_W-1:0] wbyte;
    logic [REG_W-1:0] ctrl_reg [NUM_CTRL];
    logic [REG_W-1:0] lat_reg [NUM_LAT];
    logic [REG_W-1:0] mask_reg [NUM_LAT];
    logic [REG_W-1:0] evt [NUM_LAT];
    logic [NUM_LAT-1:0] pend;
    logic [REG_W-1:0] tx_info;
    logic [REG_W-1:0] rx_info;
    logic [REG_W-1:0] gfi;
    logic [REG_W-1:0] gli;
    logic [REG_W-1:0] gti;
    logic [REG_W-1:0] rd_data;
    logic rd_ok;
    logic [APB_DW-1:0] prdata_reg;
    logic pslverr_reg;
    logic [3:0] clk_sync1_reg;
    logic [3:0] clk_sync2_reg;
    logic [FS_CNT_W-1:0] fs_cnt_reg;
    logic fs_pulse_reg;
    logic ref_out_reg;
    logic bp_ref_reg;
    ref_src_t ref_src;

    // Register access
    assign idx = paddr[ADDR_W-1:2];
    assign wbyte = pwdata[REG_W-1:0];
    // Upper byte lanes ignored
    assign wr_access = psel && penable && pwrite && pstrb[0];
    // Read data taken at setup, so no wait states
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    assign evt[L_TX] = REG_W'(tx_events);
    assign evt[L_RX_A] = REG_W'(rx_events_a);
    assign evt[L_RX_B] = REG_W'(rx_events_b);
    assign evt[L_LIU] = REG_W'(liu_events);
    assign evt[L_TESTER] = REG_W'(tester_events);

    // Control storage
    for (genvar i = 0; i < NUM_CTRL; i++) begin : g_ctrl
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                ctrl_reg[i] <= CTRL_RST; // [R7]
            end else if (wr_access && idx == CTRL_IDX[i]) begin
                ctrl_reg[i] <= wbyte;
            end
        end
    end

    // Latched status with masks
    for (genvar k = 0; k < NUM_LAT; k++) begin : g_lat
        logic lat_hit;
        logic mask_hit;
        assign lat_hit = wr_access && idx == IDX_W'(IDX_LATCHED_BASE + k);
        assign mask_hit = wr_access && idx == IDX_W'(IDX_MASK_BASE + k);

        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                lat_reg[k] <= '0;
            end else begin
                // A new event beats a same-cycle clear
                lat_reg[k] <= (lat_reg[k] & ~(lat_hit ? wbyte : '0)) | evt[k]; // [R21] [R22]
            end
        end

        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                mask_reg[k] <= MASK_RST;
            end else if (mask_hit) begin
                mask_reg[k] <= wbyte;
            end
        end

        assign pend[k] = |(lat_reg[k] & ~mask_reg[k]); // [R22] [R20]
    end

    // Information levels, live
    assign tx_info = {7'h00, pend[L_TX]}; // [R19] [R20]
    assign rx_info = {6'h00, pend[L_RX_B], pend[L_RX_A]}; // [R19] [R20]
    assign gfi = {6'h00, |rx_info, |tx_info}; // [R19]
    assign gli = {7'h00, pend[L_LIU]}; // [R19]
    assign gti = {7'h00, pend[L_TESTER]}; // [R19]

    // Pulls low only; combinational for same-cycle release
    assign irq_n_o = 1'b0; // [R23]
    assign irq_n_oe = |{gfi, gli, gti}; // [R23] [R24]

    // Read mux
    always_comb begin
        rd_data = '0;
        rd_ok = 1'b0;
        for (int i = 0; i < NUM_CTRL; i++) begin
            if (idx == CTRL_IDX[i]) begin
                rd_data = ctrl_reg[i];
                rd_ok = 1'b1;
            end
        end
        for (int k = 0; k < NUM_LAT; k++) begin
            if (idx == IDX_W'(IDX_LATCHED_BASE + k)) begin
                rd_data = lat_reg[k];
                rd_ok = 1'b1;
            end
            if (idx == IDX_W'(IDX_MASK_BASE + k)) begin
                rd_data = mask_reg[k];
                rd_ok = 1'b1;
            end
        end
        case (idx)
            IDX_IDENTITY_REG: begin
                rd_data = IDENTITY_CODE;
                rd_ok = 1'b1;
            end
            IDX_GLOBAL_FRAMER_INT_INFO: begin
                rd_data = gfi; // [R18]
                rd_ok = 1'b1;
            end
            IDX_GLOBAL_LIU_INT_INFO: begin
                rd_data = gli; // [R18]
                rd_ok = 1'b1;
            end
            IDX_GLOBAL_TESTER_INT_INFO: begin
                rd_data = gti; // [R18]
                rd_ok = 1'b1;
            end
            IDX_TX_INT_INFO: begin
                rd_data = tx_info;
                rd_ok = 1'b1;
            end
            IDX_RX_INT_INFO: begin
                rd_data = rx_info;
                rd_ok = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= {24'h00_0000, rd_data};
            pslverr_reg <= !rd_ok;
        end
    end

    // Resets held while bit set and during hardware reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_framer_rst <= 1'b1; // [R7]
            tx_framer_rst <= 1'b1; // [R7]
            tester_rst <= 1'b1; // [R7]
            liu_rst <= 1'b1; // [R7]
            rx_hdlc_rst <= 1'b1;
            tx_hdlc_rst <= 1'b1;
            rx_elastic_rst <= 1'b1;
            tx_elastic_rst <= 1'b1;
            rx_bitcode_rst <= 1'b1;
        end else begin
            rx_framer_rst <= ctrl_reg[C_GFR][B_GLOBAL_RST] | ctrl_reg[C_RMM][B_MODE_RST]; // [R11] [R12]
            tx_framer_rst <= ctrl_reg[C_GFR][B_GLOBAL_RST] | ctrl_reg[C_TMM][B_MODE_RST]; // [R11] [R12]
            tester_rst <= ctrl_reg[C_GFR][B_GLOBAL_RST]; // [R11]
            liu_rst <= ctrl_reg[C_GLR][B_GLOBAL_RST]; // [R11]
            rx_hdlc_rst <= ctrl_reg[C_RHC][B_RX_HDLC_RST]; // [R13]
            tx_hdlc_rst <= ctrl_reg[C_THC][B_TX_HDLC_RST]; // [R13]
            rx_elastic_rst <= ctrl_reg[C_REC][B_ELASTIC_RST]; // [R14]
            tx_elastic_rst <= ctrl_reg[C_TEC][B_ELASTIC_RST]; // [R14]
            rx_bitcode_rst <= ctrl_reg[C_RBOC][B_BITCODE_RST]; // [R14]
        end
    end

    // Code definition write: one restart pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            code_integ_restart <= 1'b0;
        end else begin
            code_integ_restart <= wr_access && (idx == IDX_LOOP_UP_CODE_DEF
                || idx == IDX_LOOP_DOWN_CODE_DEF || idx == IDX_SPARE_CODE_DEF); // [R15]
        end
    end

    // Framer enables and line interface power controls
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_framer_enable <= 1'b0;
            tx_framer_enable <= 1'b0;
            tx_power_down <= 1'b0;
            rx_power_down <= 1'b0;
            tx_line_oe <= 1'b0;
        end else begin
            rx_framer_enable <= ctrl_reg[C_RMM][B_FRAMER_ENABLE];
            tx_framer_enable <= ctrl_reg[C_TMM][B_FRAMER_ENABLE];
            tx_power_down <= ctrl_reg[C_LMC][B_TX_POWER_DOWN]; // [R9]
            rx_power_down <= ctrl_reg[C_LMC][B_RX_POWER_DOWN]; // [R9]
            // Power-down overrides the enable
            tx_line_oe <= ctrl_reg[C_LMC][B_TX_OUTPUT_ENABLE]
                && !ctrl_reg[C_LMC][B_TX_POWER_DOWN]; // [R9] [R10]
        end
    end

    // Synthesizer settings from clock registers
    assign bp_rate_sel = ctrl_reg[C_GCC][B_BP_RATE_LO +: 2]; // [R2]
    assign mclk_prescale = ctrl_reg[C_MCC][B_MCLK_MULT_LO +: 3]; // [R1]
    assign mclk_base_t1 = ctrl_reg[C_MCC][B_MCLK_BASE_T1]; // [R1]
    assign ref_src = ref_src_t'(ctrl_reg[C_GCC][B_REF_SRC_LO +: 2]);

    // Foreign clocks sampled as levels; good for rates well under 10 MHz
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_sync1_reg <= '0;
            clk_sync2_reg <= '0;
        end else begin
            clk_sync1_reg <= {ref_clk_pin_i, rx_recovered_clk, master_clk_e1_rate,
                master_clk_t1_rate};
            clk_sync2_reg <= clk_sync1_reg;
        end
    end

    // Reference select and pin drive
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bp_ref_reg <= 1'b0;
            ref_out_reg <= 1'b0;
        end else begin
            case (ref_src)
                REF_PIN: bp_ref_reg <= clk_sync2_reg[3]; // [R4]
                REF_RECOVERED: bp_ref_reg <= clk_sync2_reg[2]; // [R4]
                REF_MCLK: bp_ref_reg <= mclk_base_t1 ? clk_sync2_reg[0] : clk_sync2_reg[1]; // [R4]
                default: bp_ref_reg <= mclk_base_t1 ? clk_sync2_reg[0] : clk_sync2_reg[1];
            endcase
            ref_out_reg <= ctrl_reg[C_GCC][B_REF_OUT_T1] ? clk_sync2_reg[0]
                : clk_sync2_reg[1]; // [R3] [R5]
        end
    end

    assign bp_ref_clk = bp_ref_reg;
    assign ref_clk_pin_o = ref_out_reg;
    // No drive while the pin is the reference
    assign ref_clk_pin_oe = ctrl_reg[C_GCC][B_REF_PIN_OUT] && ref_src != REF_PIN; // [R3] [R5]

    // 8 kHz frame sync, one core_clk wide
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fs_cnt_reg <= '0;
            fs_pulse_reg <= 1'b0;
        end else if (fs_cnt_reg == FS_CNT_W'(FRAME_SYNC_CYCLES - 1)) begin
            fs_cnt_reg <= '0;
            fs_pulse_reg <= 1'b1; // [R6]
        end else begin
            fs_cnt_reg <= fs_cnt_reg + FS_CNT_W'(1);
            fs_pulse_reg <= 1'b0;
        end
    end

    assign tx_frame_sync_pin_o = fs_pulse_reg;
    assign tx_frame_sync_pin_oe = ctrl_reg[C_GCC][B_BUS_MASTER]; // [R6]

endmodule

// file: core/global_ctrl_pkg.sv
// Constants for the global clock, reset and interrupt block.
// Byte address on APB is four times the register index.
package global_ctrl_pkg;

    localparam int APB_DW = 32;
    localparam int ADDR_W = 10;
    localparam int REG_W = 8;
    localparam int IDX_W = 8;

    // Global register indices
    localparam logic [7:0] IDX_GLOBAL_FRAMER_RESET = 8'hF0;
    localparam logic [7:0] IDX_GLOBAL_LIU_RESET = 8'hF1;
    localparam logic [7:0] IDX_GLOBAL_CLOCK_CTRL = 8'hF2;
    localparam logic [7:0] IDX_IDENTITY_REG = 8'hF3;
    localparam logic [7:0] IDX_GLOBAL_FRAMER_INT_INFO = 8'hF4;
    localparam logic [7:0] IDX_GLOBAL_LIU_INT_INFO = 8'hF5;
    localparam logic [7:0] IDX_GLOBAL_TESTER_INT_INFO = 8'hF6;
    localparam logic [7:0] IDX_MASTER_CLK_CFG = 8'hF7;

    // Per-block register indices
    localparam logic [7:0] IDX_LIU_MAINT_CTRL = 8'h10;
    localparam logic [7:0] IDX_RX_MASTER_MODE = 8'h20;
    localparam logic [7:0] IDX_TX_MASTER_MODE = 8'h21;
    localparam logic [7:0] IDX_RX_HDLC_CTRL = 8'h30;
    localparam logic [7:0] IDX_TX_HDLC_CTRL_A = 8'h31;
    localparam logic [7:0] IDX_RX_ELASTIC_CTRL = 8'h40;
    localparam logic [7:0] IDX_TX_ELASTIC_CTRL = 8'h41;
    localparam logic [7:0] IDX_RX_BITCODE_CTRL = 8'h50;
    localparam logic [7:0] IDX_LOOP_UP_CODE_DEF = 8'h51;
    localparam logic [7:0] IDX_LOOP_DOWN_CODE_DEF = 8'h52;
    localparam logic [7:0] IDX_SPARE_CODE_DEF = 8'h53;
    localparam logic [7:0] IDX_TX_INT_INFO = 8'h60;
    localparam logic [7:0] IDX_RX_INT_INFO = 8'h61;
    localparam logic [7:0] IDX_LATCHED_BASE = 8'h70;
    localparam logic [7:0] IDX_MASK_BASE = 8'h78;

    // Control register slots
    localparam int NUM_CTRL = 15;
    localparam int C_GFR = 0;
    localparam int C_GLR = 1;
    localparam int C_GCC = 2;
    localparam int C_MCC = 3;
    localparam int C_LMC = 4;
    localparam int C_RMM = 5;
    localparam int C_TMM = 6;
    localparam int C_RHC = 7;
    localparam int C_THC = 8;
    localparam int C_REC = 9;
    localparam int C_TEC = 10;
    localparam int C_RBOC = 11;
    localparam int C_LUP = 12;
    localparam int C_LDN = 13;
    localparam int C_SPR = 14;
    localparam logic [7:0] CTRL_IDX [NUM_CTRL] = '{
        IDX_GLOBAL_FRAMER_RESET, IDX_GLOBAL_LIU_RESET, IDX_GLOBAL_CLOCK_CTRL,
        IDX_MASTER_CLK_CFG, IDX_LIU_MAINT_CTRL, IDX_RX_MASTER_MODE, IDX_TX_MASTER_MODE,
        IDX_RX_HDLC_CTRL, IDX_TX_HDLC_CTRL_A, IDX_RX_ELASTIC_CTRL, IDX_TX_ELASTIC_CTRL,
        IDX_RX_BITCODE_CTRL, IDX_LOOP_UP_CODE_DEF, IDX_LOOP_DOWN_CODE_DEF,
        IDX_SPARE_CODE_DEF};
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // Latched status groups
    localparam int NUM_LAT = 5;
    localparam int L_TX = 0;
    localparam int L_RX_A = 1;
    localparam int L_RX_B = 2;
    localparam int L_LIU = 3;
    localparam int L_TESTER = 4;

    // Field positions
    localparam int B_GLOBAL_RST = 0;
    localparam int B_FRAMER_ENABLE = 0;
    localparam int B_MODE_RST = 1;
    localparam int B_RX_HDLC_RST = 6;
    localparam int B_TX_HDLC_RST = 5;
    localparam int B_ELASTIC_RST = 2;
    localparam int B_BITCODE_RST = 7;
    localparam int B_TX_POWER_DOWN = 0;
    localparam int B_RX_POWER_DOWN = 1;
    localparam int B_TX_OUTPUT_ENABLE = 2;
    localparam int B_BP_RATE_LO = 0;
    localparam int B_REF_SRC_LO = 2;
    localparam int B_REF_PIN_OUT = 4;
    localparam int B_REF_OUT_T1 = 5;
    localparam int B_BUS_MASTER = 7;
    localparam int B_MCLK_MULT_LO = 0;
    localparam int B_MCLK_BASE_T1 = 3;

    // Backplane rate codes: 2.048, 4.096, 8.192, 16.384 MHz
    typedef enum logic [1:0] {
        BP_2M048 = 2'b00, BP_4M096 = 2'b01, BP_8M192 = 2'b10, BP_16M384 = 2'b11
    } bp_rate_t;

    typedef enum logic [1:0] {
        REF_MCLK = 2'b00, REF_PIN = 2'b01, REF_RECOVERED = 2'b10, REF_SPARE = 2'b11
    } ref_src_t;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int FRAME_SYNC_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FS_CNT_W = 12;

endpackage

// file: tb/global_clock_reset_interrupt_ctrl_tb.sv
// Bench for the global clock, reset and interrupt block.
// Assumes an APB slave on core_clk; clock inputs come from line_clock_model.
`timescale 1ns/100ps

module global_clock_reset_interrupt_ctrl_tb;
    import global_ctrl_pkg::*;
    localparam logic [7:0] ID_VAL = 8'hA5; // Arbitrary value
    localparam logic [7:0] RI [9] = '{8'hF0, 8'hF1, 8'h20, 8'h21, 8'h30, 8'h31, 8'h40,
        8'h41, 8'h50};
    localparam logic [7:0] RD [9] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h40, 8'h20, 8'h04,
        8'h04, 8'h80};
    localparam logic [8:0] RM [9] = '{9'h1C0, 9'h020, 9'h100, 9'h080, 9'h010, 9'h008,
        9'h004, 9'h002, 9'h001};
    localparam logic [7:0] LM [3] = '{8'h04, 8'h05, 8'h02};
    localparam logic [4:0] LX [3] = '{5'h19, 5'h1C, 5'h1A};
    localparam logic [7:0] RC [3] = '{8'h30, 8'h18, 8'h14};
    localparam logic RO [3] = '{1'b1, 1'b1, 1'b0};
    localparam logic [7:0] GI [5] = '{8'hF4, 8'hF4, 8'hF4, 8'hF5, 8'hF6};
    localparam logic [7:0] GV [5] = '{8'h01, 8'h02, 8'h02, 8'h01, 8'h01};
    localparam logic [7:0] PI [5] = '{8'h60, 8'h61, 8'h61, 8'hF5, 8'hF6};
    localparam logic [7:0] PV [5] = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h01};
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq_n_o, irq_n_oe, err;
    logic [ADDR_W-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] ev [5];
    logic master_clk_t1_rate, master_clk_e1_rate, rx_recovered_clk, ref_clk_pin_i;
    logic ref_clk_pin_o, ref_clk_pin_oe, bp_ref_clk, mclk_base_t1, pa, pb;
    logic tx_frame_sync_pin_o, tx_frame_sync_pin_oe, code_integ_restart;
    logic [1:0] bp_rate_sel;
    logic [2:0] mclk_prescale;
    logic rx_framer_rst, tx_framer_rst, tester_rst, liu_rst, rx_hdlc_rst, tx_hdlc_rst;
    logic rx_elastic_rst, tx_elastic_rst, rx_bitcode_rst;
    logic rx_framer_enable, tx_framer_enable, tx_power_down, rx_power_down, tx_line_oe;
    logic [8:0] rvec;
    logic [4:0] lvec;
    int n_fail, cmp_count, n, ta, tb;

    assign rvec = {rx_framer_rst, tx_framer_rst, tester_rst, liu_rst, rx_hdlc_rst,
        tx_hdlc_rst, rx_elastic_rst, tx_elastic_rst, rx_bitcode_rst};
    assign lvec = {rx_framer_enable, tx_framer_enable, tx_power_down, rx_power_down,
        tx_line_oe};

    line_clock_model clk_src (.*);
    global_clock_reset_interrupt_ctrl #(.IDENTITY_CODE(ID_VAL), .EVT_W(8)) uut (
        .*,
        .tx_events(ev[0]),
        .rx_events_a(ev[1]),
        .rx_events_b(ev[2]),
        .liu_events(ev[3]),
        .tester_events(ev[4])
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Held until pready is high at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
        input logic s);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        pstrb <= {3'b000, s};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd, 1'b1);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, 1'b1);
        chk("prdata", {24'h00_0000, exp}, rd);
    endtask

    task automatic tick(inout int k);
        @(posedge core_clk);
        #1;
        k++;
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        foreach (ev[i]) ev[i] = 8'h00;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(posedge core_clk);
        #1 chk("rst_out", 9'h1FF, rvec);
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rchk(8'hF3, ID_VAL);
        wr(8'hF3, 8'h00);
        rchk(8'hF3, ID_VAL);
        foreach (CTRL_IDX[i]) rchk(CTRL_IDX[i], CTRL_RST);
        apb(1'b0, 8'h00, 8'h00, 1'b1);
        chk("pslverr", 1, err);
        apb(1'b1, 8'h10, 8'h07, 1'b0);
        rchk(8'h10, 8'h00);
        wr(8'hF7, 8'h0F);
        #1 chk("mclk_cfg", 4'hF, {mclk_base_t1, mclk_prescale});
        wr(8'hF7, 8'h08);
        for (int r = 0; r < 4; r++) begin
            wr(8'hF2, 8'h80 | 8'(r));
            repeat (7) @(posedge core_clk);
            chk("bp_rate", 4 + r, {tx_frame_sync_pin_oe, bp_rate_sel});
        end
        repeat (2) begin
            n = 0;
            do tick(n); while (tx_frame_sync_pin_o !== 1'b1 && n < 3000);
        end
        chk("fs_gap", FRAME_SYNC_CYCLES, n);
        for (int s = 0; s < 3; s++) begin
            wr(8'hF2, RC[s]);
            {ta, tb} = '0;
            repeat (80) begin
                pa = ref_clk_pin_o;
                pb = bp_ref_clk;
                tick(n);
                ta += int'(pa !== ref_clk_pin_o);
                tb += int'(pb !== bp_ref_clk);
            end
            chk("ref_oe", RO[s], ref_clk_pin_oe);
            if (RO[s]) chk("ref_moves", 1, ta > 2);
            chk("bp_ref_moves", 1, tb > 2);
        end
        for (int i = 4; i < NUM_CTRL; i++) wr(CTRL_IDX[i], 8'h00);
        wr(8'h20, 8'h01);
        wr(8'h21, 8'h01);
        for (int i = 0; i < 3; i++) begin
            wr(8'h10, LM[i]);
            repeat (2) @(posedge core_clk);
            #1 chk("liu_ctrl", LX[i], lvec);
        end
        for (int i = 0; i < 9; i++) begin
            wr(RI[i], RD[i]);
            repeat (2) @(posedge core_clk);
            #1 chk("rst_out", RM[i], rvec);
            wr(RI[i], 8'h00);
        end
        repeat (2) @(posedge core_clk);
        #1 chk("rst_out", 0, rvec);
        for (int i = 0; i < 4; i++) begin
            wr(8'h50 + 8'(i), 8'h00);
            #1 chk("restart", i > 0, code_integ_restart);
        end
        for (int g = 0; g < 5; g++) begin
            wr(8'h78 + 8'(g), 8'h01);
            @(posedge core_clk);
            ev[g] <= 8'h81;
            @(posedge core_clk);
            ev[g] <= 8'h00;
            #1 chk("irq", 1, irq_n_oe);
            rchk(8'h70 + 8'(g), 8'h81);
            rchk(GI[g], GV[g]);
            rchk(PI[g], PV[g]);
            wr(8'h70 + 8'(g), 8'h00);
            rchk(8'h70 + 8'(g), 8'h81);
            wr(8'h70 + 8'(g), 8'h80);
            #1 chk("irq", 0, irq_n_oe);
            rchk(GI[g], 8'h00);
            wr(8'h78 + 8'(g), 8'h00);
            #1 chk("irq", 1, irq_n_oe);
            wr(8'h70 + 8'(g), 8'h01);
            #1 chk("irq", 0, irq_n_oe);
        end
        give_verdict();
    end
endmodule

// file: tb/global_ctrl_sva.sv
// Port assertions for the global clock, reset and interrupt block.
// Bound into every instance of the block; watches its ports only.
`timescale 1ns/100ps

module global_ctrl_sva
    import global_ctrl_pkg::*;
#(
    parameter int EVT_W = 8
) (
    input logic core_clk,
    input logic rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [global_ctrl_pkg::ADDR_W-1:0] paddr,
    input logic [global_ctrl_pkg::APB_DW-1:0] pwdata,
    input logic [3:0] pstrb,
    input logic [EVT_W-1:0] tx_events,
    input logic [EVT_W-1:0] rx_events_a,
    input logic [EVT_W-1:0] rx_events_b,
    input logic [EVT_W-1:0] liu_events,
    input logic [EVT_W-1:0] tester_events,
    input logic irq_n_o,
    input logic irq_n_oe,
    input logic ref_clk_pin_oe,
    input logic [1:0] bp_rate_sel,
    input logic tx_frame_sync_pin_o,
    input logic tx_frame_sync_pin_oe,
    input logic tester_rst,
    input logic liu_rst,
    input logic code_integ_restart,
    input logic tx_power_down,
    input logic tx_line_oe
);
    import global_ctrl_pkg::*;
    logic [7:0] idx;
    logic wr_en, code_wr, gcc_wr, cause, seen;
    logic [11:0] gap;

    assign idx = paddr[9:2];
    assign wr_en = psel && penable && pwrite && pstrb[0];
    assign code_wr = wr_en && idx inside {8'h51, 8'h52, 8'h53};
    assign gcc_wr = wr_en && idx == 8'hF2;
    assign cause = wr_en || |{tx_events, rx_events_a, rx_events_b, liu_events, tester_events};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Gap since last pulse; first pulse only arms it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap <= 12'h000;
            seen <= 1'b0;
        end else if (tx_frame_sync_pin_o) begin
            gap <= 12'h000;
            seen <= 1'b1;
        end else begin
            gap <= gap + 12'h001;
        end
    end

    pin_low_a: assert property (irq_n_o == 1'b0)
        else $error("interrupt pin drives high");
    irq_cause_a: assert property ($rose(irq_n_oe) |-> $past(cause))
        else $error("interrupt with no cause");
    restart_on_a: assert property (code_wr |=> code_integ_restart)
        else $error("no restart after code write");
    restart_only_a: assert property (code_integ_restart |-> $past(code_wr))
        else $error("restart without code write");
    bp_cfg_a: assert property (gcc_wr |=> bp_rate_sel == $past(pwdata[1:0])
        && tx_frame_sync_pin_oe == $past(pwdata[7]))
        else $error("clock control not applied");
    ref_dir_a: assert property (gcc_wr |=> ref_clk_pin_oe == ($past(pwdata[4])
        && $past(pwdata[3:2]) != 2'b01))
        else $error("reference pin direction wrong");
    tester_rst_a: assert property (wr_en && idx == 8'hF0 |->
        ##2 tester_rst == $past(pwdata[0], 2))
        else $error("framer reset bit not followed");
    liu_rst_a: assert property (wr_en && idx == 8'hF1 |->
        ##2 liu_rst == $past(pwdata[0], 2))
        else $error("line reset bit not followed");
    pd_float_a: assert property (tx_power_down |-> !tx_line_oe)
        else $error("driven while powered down");
    fs_period_a: assert property (seen |->
        tx_frame_sync_pin_o == (gap == 12'(FRAME_SYNC_CYCLES - 1)))
        else $error("frame sync spacing wrong");
endmodule

bind global_clock_reset_interrupt_ctrl global_ctrl_sva #(.EVT_W(EVT_W)) sva_i (.*);

// file: tb/line_clock_model.sv
// Free-running sources for the block's clock inputs.
// Periods are unrelated to core_clk.
`timescale 1ns/100ps

module line_clock_model (
    output logic master_clk_t1_rate,
    output logic master_clk_e1_rate,
    output logic rx_recovered_clk,
    output logic ref_clk_pin_i
);
    // Odd half periods keep edges off the core_clk grid
    initial master_clk_t1_rate = 1'b0;
    always #323.9 master_clk_t1_rate = ~master_clk_t1_rate;
    initial master_clk_e1_rate = 1'b0;
    always #244.1 master_clk_e1_rate = ~master_clk_e1_rate;
    initial rx_recovered_clk = 1'b1;
    always #323.7 rx_recovered_clk = ~rx_recovered_clk;
    initial ref_clk_pin_i = 1'b0;
    always #244.3 ref_clk_pin_i = ~ref_clk_pin_i;
endmodule
